// ===== cbu_defs.vh
// Constants for the conditional branch unit
`ifndef CBU_DEFS_VH
`define CBU_DEFS_VH

// Branch word layout: opcode in [15:10], offset in [9:3], selector in [2:0]
`define CBU_WORD_W 16
`define CBU_PC_W 16
`define CBU_OFS_W 7
`define CBU_OFS_LSB 3
`define CBU_OFS_MSB 9
`define CBU_SEL_MSB 2
`define CBU_SEL_LSB 0
`define CBU_OP_MSB 15
`define CBU_OP_LSB 10
`define CBU_OP_SET 6'h3C
`define CBU_OP_CLR 6'h3D

// Status flag positions
`define CBU_FLAG_W 8
`define CBU_F_CARRY 3'h0
`define CBU_F_ZERO 3'h1
`define CBU_F_MINUS 3'h2
`define CBU_F_WRAP 3'h3
`define CBU_F_SIGN 3'h4
`define CBU_F_NIBBLE 3'h5
`define CBU_F_USER 3'h6
`define CBU_F_IEN 3'h7

// Condition codes
`define CBU_C_EQ 4'h0
`define CBU_C_NE 4'h1
`define CBU_C_CS 4'h2
`define CBU_C_CC 4'h3
`define CBU_C_MI 4'h4
`define CBU_C_PL 4'h5
`define CBU_C_GE 4'h6
`define CBU_C_LT 4'h7
`define CBU_C_HS 4'h8
`define CBU_C_HC 4'h9
`define CBU_C_TS 4'hA
`define CBU_C_TC 4'hB
`define CBU_C_VS 4'hC
`define CBU_C_VC 4'hD
`define CBU_C_NONE 4'hF

// Cycle counts
`define CBU_CYC_FALL 2'h1
`define CBU_CYC_TAKEN 2'h2

`define CBU_PC_RESET 16'h0000

`endif

// ===== cbu_cond_decode.v
// Maps an opcode and bit selector to a condition code
`timescale 1ns/10ps
`include "cbu_defs.vh"

module cbu_cond_decode (
    // Branch word fields
    input wire [5:0] i_opcode,
    input wire [2:0] i_sel,
    // Decoded condition
    output reg [3:0] o_cond,
    output reg o_is_branch
);
    always @* begin
        o_is_branch = (i_opcode == `CBU_OP_SET) ||
            (i_opcode == `CBU_OP_CLR);
        o_cond = `CBU_C_NONE;
        if (i_opcode == `CBU_OP_SET) begin
            case (i_sel)
                `CBU_F_ZERO: o_cond = `CBU_C_EQ;
                `CBU_F_CARRY: o_cond = `CBU_C_CS;
                `CBU_F_MINUS: o_cond = `CBU_C_MI;
                `CBU_F_SIGN: o_cond = `CBU_C_LT;
                `CBU_F_NIBBLE: o_cond = `CBU_C_HS;
                `CBU_F_USER: o_cond = `CBU_C_TS;
                `CBU_F_WRAP: o_cond = `CBU_C_VS;
                default: o_is_branch = 1'b0;
            endcase
        end else if (i_opcode == `CBU_OP_CLR) begin
            case (i_sel)
                `CBU_F_ZERO: o_cond = `CBU_C_NE;
                `CBU_F_CARRY: o_cond = `CBU_C_CC;
                `CBU_F_MINUS: o_cond = `CBU_C_PL;
                `CBU_F_SIGN: o_cond = `CBU_C_GE;
                `CBU_F_NIBBLE: o_cond = `CBU_C_HC;
                `CBU_F_USER: o_cond = `CBU_C_TC;
                `CBU_F_WRAP: o_cond = `CBU_C_VC;
                default: o_is_branch = 1'b0;
            endcase
        end
    end
endmodule // cbu_cond_decode

// ===== cbu_pc_adder.v
// Adds a sign-extended offset plus one to the program counter
`timescale 1ns/10ps
`include "cbu_defs.vh"

module cbu_pc_adder #(
    parameter PC_W = `CBU_PC_W,
    parameter OFS_W = `CBU_OFS_W
) (
    // Operands
    input wire [PC_W-1:0] i_pc,
    input wire [OFS_W-1:0] i_offset,
    // Results
    output wire [PC_W-1:0] o_target,
    output wire [PC_W-1:0] o_next
);
    wire [PC_W-1:0] ofs_ext;
    assign ofs_ext = {{(PC_W-OFS_W){i_offset[OFS_W-1]}}, i_offset};
    // Wraps modulo the PC width, like the program memory space
    assign o_target = i_pc + ofs_ext + {{(PC_W-1){1'b0}}, 1'b1};
    assign o_next = i_pc + {{(PC_W-1){1'b0}}, 1'b1};
endmodule // cbu_pc_adder

// ===== cbu_branch_unit.v
// Conditional relative branch evaluation and program counter update
//
// What this block does
// - branch_on_equal: taken when equal_result_flag is 1.
// - branch_on_unequal: taken when equal_result_flag is 0.
// - branch_on_carry_true: taken when borrow_out_bit is 1.
// - branch_on_carry_false: taken when borrow_out_bit is 0.
// - branch_unsigned_ge: taken exactly when borrow_out_bit is 0.
// - branch_unsigned_lt: taken exactly when borrow_out_bit is 1.
// - branch_on_minus: taken exactly when msb_result_flag is 1.
// - branch_on_plus: taken exactly when msb_result_flag is 0.
// - branch_signed_ge: taken when msb xor signed_wrap is 0.
// - branch_signed_lt: taken when msb xor signed_wrap is 1.
// - branch_nibble_carry_true: taken when nibble_carry_bit is 1.
// - branch_nibble_carry_false: taken when nibble_carry_bit is 0.
// - branch_user_flag_true: taken when user_copy_flag is 1.
// - branch_user_flag_false: taken when user_copy_flag is 0.
// - branch_on_wrap: taken when signed_wrap_flag is 1.
// - Taken branch loads PC plus offset plus one.
// - Flags untouched; one cycle if not taken, two if taken.
`timescale 1ns/10ps
`include "cbu_defs.vh"

module cbu_branch_unit #(
    parameter PC_W = `CBU_PC_W,
    parameter WORD_W = `CBU_WORD_W
) (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_reset,
    // Instruction issue
    input wire i_valid,
    input wire [WORD_W-1:0] i_word,
    input wire [PC_W-1:0] i_pc,
    // Status flags from the core
    input wire [`CBU_FLAG_W-1:0] i_flags,
    // Program counter update
    output reg o_ready,
    output reg o_pc_load,
    output reg [PC_W-1:0] o_pc,
    output reg o_taken,
    output reg o_done,
    output reg [1:0] o_cycles,
    output reg o_is_branch,
    // Flags passed back unchanged
    output reg [`CBU_FLAG_W-1:0] o_flags
);
    localparam ST_IDLE = 1'b0;
    localparam ST_TAKEN = 1'b1;

    reg state;
    reg next_state;
    reg [PC_W-1:0] target_hold;
    reg next_pc_load;
    reg [PC_W-1:0] next_pc;
    reg next_taken;
    reg next_done;
    reg [1:0] next_cycles;
    reg next_is_branch;
    reg next_ready;
    reg cond_true;

    wire [3:0] cond;
    wire dec_branch;
    wire [PC_W-1:0] target;
    wire [PC_W-1:0] seq_pc;

    cbu_cond_decode u_dec (
        .i_opcode(i_word[`CBU_OP_MSB:`CBU_OP_LSB]),
        .i_sel(i_word[`CBU_SEL_MSB:`CBU_SEL_LSB]),
        .o_cond(cond),
        .o_is_branch(dec_branch)
    );

    cbu_pc_adder #(
        .PC_W(PC_W),
        .OFS_W(`CBU_OFS_W)
    ) u_add (
        .i_pc(i_pc),
        .i_offset(i_word[`CBU_OFS_MSB:`CBU_OFS_LSB]),
        .o_target(target),
        .o_next(seq_pc)
    );

    // HS and HC test the nibble flag, not the carry flag
    function eval_cond;
        input [3:0] c;
        input [`CBU_FLAG_W-1:0] f;
        begin
            case (c)
                `CBU_C_EQ: eval_cond = f[`CBU_F_ZERO];
                `CBU_C_NE: eval_cond = ~f[`CBU_F_ZERO];
                `CBU_C_CS: eval_cond = f[`CBU_F_CARRY];
                `CBU_C_CC: eval_cond = ~f[`CBU_F_CARRY];
                `CBU_C_MI: eval_cond = f[`CBU_F_MINUS];
                `CBU_C_PL: eval_cond = ~f[`CBU_F_MINUS];
                `CBU_C_GE: eval_cond =
                    ~(f[`CBU_F_MINUS] ^ f[`CBU_F_WRAP]);
                `CBU_C_LT: eval_cond =
                    f[`CBU_F_MINUS] ^ f[`CBU_F_WRAP];
                `CBU_C_HS: eval_cond = f[`CBU_F_NIBBLE];
                `CBU_C_HC: eval_cond = ~f[`CBU_F_NIBBLE];
                `CBU_C_TS: eval_cond = f[`CBU_F_USER];
                `CBU_C_TC: eval_cond = ~f[`CBU_F_USER];
                `CBU_C_VS: eval_cond = f[`CBU_F_WRAP];
                `CBU_C_VC: eval_cond = ~f[`CBU_F_WRAP];
                default: eval_cond = 1'b0;
            endcase
        end
    endfunction

    always @* begin
        cond_true = eval_cond(cond, i_flags);
        next_state = state;
        next_pc_load = 1'b0;
        next_pc = o_pc;
        next_taken = 1'b0;
        next_done = 1'b0;
        next_cycles = o_cycles;
        next_is_branch = o_is_branch;
        next_ready = 1'b1;
        case (state)
            ST_IDLE: begin
                if (i_valid && dec_branch) begin
                    next_is_branch = 1'b1;
                    if (cond_true) begin
                        // Second cycle refetches at the target
                        next_state = ST_TAKEN;
                        next_ready = 1'b0;
                    end else begin
                        next_pc_load = 1'b1;
                        next_pc = seq_pc;
                        next_done = 1'b1;
                        next_cycles = `CBU_CYC_FALL;
                    end
                end else if (i_valid) begin
                    next_is_branch = 1'b0;
                end
            end
            ST_TAKEN: begin
                next_state = ST_IDLE;
                next_pc_load = 1'b1;
                next_pc = target_hold;
                next_taken = 1'b1;
                next_done = 1'b1;
                next_cycles = `CBU_CYC_TAKEN;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= ST_IDLE;
            target_hold <= `CBU_PC_RESET;
            o_ready <= 1'b1;
            o_pc_load <= 1'b0;
            o_pc <= `CBU_PC_RESET;
            o_taken <= 1'b0;
            o_done <= 1'b0;
            o_cycles <= 2'h0;
            o_is_branch <= 1'b0;
            o_flags <= {`CBU_FLAG_W{1'b0}};
        end else begin
            state <= next_state;
            if (state == ST_IDLE && i_valid) begin
                target_hold <= target;
            end
            o_ready <= next_ready;
            o_pc_load <= next_pc_load;
            o_pc <= next_pc;
            o_taken <= next_taken;
            o_done <= next_done;
            o_cycles <= next_cycles;
            o_is_branch <= next_is_branch;
            // Flags are only echoed, never altered
            o_flags <= i_flags;
        end
    end
endmodule // cbu_branch_unit

// ===== cbu_branch_unit_asserts.sv
// Checker for the conditional branch unit ports
`timescale 1ns/10ps
`include "cbu_defs.vh"

module cbu_branch_unit_asserts #(
    parameter PC_W = 16,
    parameter WORD_W = 16
) (
    input wire i_sys_clk,
    input wire i_reset,
    input wire i_valid,
    input wire [WORD_W-1:0] i_word,
    input wire [PC_W-1:0] i_pc,
    input wire [`CBU_FLAG_W-1:0] i_flags,
    input wire o_ready,
    input wire o_pc_load,
    input wire [PC_W-1:0] o_pc,
    input wire o_taken,
    input wire o_done,
    input wire [1:0] o_cycles,
    input wire o_is_branch,
    input wire [`CBU_FLAG_W-1:0] o_flags
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    flags_pass_a: assert property ($past(!i_reset) |->
        o_flags == $past(i_flags)) else $error("flags altered");
    done_load_a: assert property (o_done == o_pc_load)
        else $error("done and load differ");
    fall_one_a: assert property ((i_valid && o_ready) ##1
        (o_ready && o_is_branch) |-> o_pc_load && !o_taken &&
        o_cycles == 2'h1 && o_pc == $past(i_pc) + 1'b1)
        else $error("fall-through wrong");
    taken_two_a: assert property ((i_valid && o_ready) ##1 !o_ready
        |=> o_pc_load && o_taken && o_cycles == 2'h2 && o_ready)
        else $error("taken branch late");
    taken_target_a: assert property (o_taken |-> o_pc ==
        $past(i_pc, 2) + {{(PC_W-7){$past(i_word[9], 2)}},
        $past(i_word[9:3], 2)} + 1'b1) else $error("bad target");
    ready_gap_a: assert property (!o_ready |=> o_ready)
        else $error("ready held low");
    pc_hold_a: assert property (!o_pc_load |-> $stable(o_pc))
        else $error("pc moved without load");
    non_branch_a: assert property ((i_valid && o_ready &&
        !(i_word[15:11] == 5'h1E && i_word[2:0] != 3'h7)) |=>
        !o_pc_load && !o_is_branch) else $error("non-branch acted");
endmodule // cbu_branch_unit_asserts

bind cbu_branch_unit cbu_branch_unit_asserts #(.PC_W(PC_W),
    .WORD_W(WORD_W)) i_cbu_branch_unit_asserts (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .i_valid(i_valid), .i_word(i_word), .i_pc(i_pc),
    .i_flags(i_flags), .o_ready(o_ready), .o_pc_load(o_pc_load),
    .o_pc(o_pc), .o_taken(o_taken), .o_done(o_done),
    .o_cycles(o_cycles), .o_is_branch(o_is_branch), .o_flags(o_flags));

// ===== cbu_branch_unit_tb.sv
// Self-checking testbench for the conditional branch unit
`timescale 1ns/10ps
`include "cbu_defs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module cbu_branch_unit_tb;
    reg i_sys_clk = 0;
    reg i_reset = 1;
    reg i_valid = 0;
    reg [15:0] i_word = 0;
    reg [15:0] i_pc = 0;
    reg [7:0] i_flags = 0;
    wire o_ready, o_pc_load, o_taken, o_done, o_is_branch;
    wire [15:0] o_pc;
    wire [1:0] o_cycles;
    wire [7:0] o_flags;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [7:0] ftab [4] = '{8'h00, 8'hFF, 8'h04, 8'hFB};

    always #5 i_sys_clk = ~i_sys_clk;

    cbu_branch_unit i_cbu_branch_unit (.i_sys_clk(i_sys_clk),
        .i_reset(i_reset), .i_valid(i_valid), .i_word(i_word),
        .i_pc(i_pc), .i_flags(i_flags), .o_ready(o_ready),
        .o_pc_load(o_pc_load), .o_pc(o_pc), .o_taken(o_taken),
        .o_done(o_done), .o_cycles(o_cycles), .o_is_branch(o_is_branch),
        .o_flags(o_flags));

    // Signed tests use minus xor wrap, not the stored sign bit
    function automatic logic exp_take(logic [15:0] w, logic [7:0] f);
        logic c;
        c = (w[2:0] == 3'h4) ? (f[2] ^ f[3]) : f[w[2:0]];
        return w[10] ? ~c : c;
    endfunction

    task automatic run(input logic [15:0] w, input logic [15:0] p,
            input logic [7:0] f);
        logic br, tk, seen;
        logic [15:0] pcv;
        logic [1:0] cy;
        logic [15:0] epc;
        int n;
        int lat;
        br = (w[15:11] == 5'h1E) && (w[2:0] != 3'h7);
        tk = br && exp_take(w, f);
        lat = br ? (tk ? 2 : 1) : 0;
        epc = tk ? p + {{9{w[9]}}, w[9:3]} + 16'h1 : p + 16'h1;
        n = 0;
        pcv = 0;
        seen = 0;
        cy = 0;
        i_word = w;
        i_pc = p;
        i_flags = f;
        i_valid = 1'b1;
        @(negedge i_sys_clk);
        // A non-branch word offered while busy must be ignored
        i_valid = tk;
        i_word = 16'h0000;
        `CHK("flags", f, o_flags)
        `CHK("ready", ~tk, o_ready)
        // Sample before waiting: a fall-through pulse stands one cycle only
        for (int i = 1; i <= 3; i++) begin
            `CHK("done", i == lat, o_done)
            if (o_pc_load === 1'b1 && n == 0) begin
                n = i;
                pcv = o_pc;
                seen = o_taken;
                cy = o_cycles;
            end
            @(negedge i_sys_clk);
            i_valid = 1'b0;
        end
        `CHK("latency", lat, n)
        if (br) begin
            `CHK("pc", epc, pcv)
            case ({w[10], w[2:0]})
                4'h0: `CHK("take cs", tk, seen)
                4'h1: `CHK("take eq", tk, seen)
                4'h2: `CHK("take mi", tk, seen)
                4'h3: `CHK("take vs", tk, seen)
                4'h4: `CHK("take lt", tk, seen)
                4'h5: `CHK("take hs", tk, seen)
                4'h6: `CHK("take ts", tk, seen)
                4'h8: `CHK("take cc", tk, seen)
                4'h9: `CHK("take ne", tk, seen)
                4'hA: `CHK("take pl", tk, seen)
                4'hC: `CHK("take ge", tk, seen)
                4'hD: `CHK("take hc", tk, seen)
                4'hE: `CHK("take tc", tk, seen)
                default: `CHK("take vc", tk, seen)
            endcase
            `CHK("cycles", tk ? 2'h2 : 2'h1, cy)
        end
        `CHK("is_branch", br, o_is_branch)
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        logic [15:0] w;
        void'($urandom(35388));
        repeat (10) @(negedge i_sys_clk);
        `CHK("reset ready", 1'b1, o_ready)
        i_reset = 0;
        // Every code and selector, both flag senses, extreme offsets
        for (int op = 0; op < 2; op++) begin
            for (int s = 0; s < 8; s++) begin
                for (int b = 0; b < 4; b++) begin
                    run({5'h1E, op[0], b[0] ? 7'h40 : 7'h3F, s[2:0]},
                        b[0] ? 16'h0000 : 16'hFFFF, ftab[b]);
                end
            end
        end
        repeat (150) begin
            w = 16'($urandom);
            if ($urandom % 4 != 0)
                w[15:11] = 5'h1E;
            run(w, 16'($urandom), 8'($urandom));
        end
        complete_run();
    end
endmodule // cbu_branch_unit_tb
